/* rtl/pmocp_top.sv */
// Output, dead time, trigger, fault, capture and DMA path of one PWM submodule
//
// Function
// - Dead time whole cycles max 0x7FF without fractions
// - With fractions, dead time field spans 0xFFFF
// - Dead time zero/one delay pair rising edges
// - Compare one..five carry 1/32 cycle fraction
// - Three fraction enables: 1, 2-3, 4-5
// - Each compare has own trigger enable
// - Postscaler limits triggers to last period
// - Separate polarity inversion for X, A, B
// - Mask buffered until force or software update
// - Cleared enable tristates the output pin
// - Fault state value driven when status enabled
// - One-shot capture clears its own enable
// - Edge select ignored with edge counter source, except that no-capture still disables the channel
// - Capture flag set when count exceeds watermark
// - Edge counter compare used for counter source
// - Filter samples every period, zero bypasses
// - Transition accepted after agreeing sample count
// - Reload flag raises DMA write request
// - Per-FIFO enable, flag raises DMA read
// - DMA source select ignored when disabled
// - Eight fault map enables per output
// - Channel zero and one share the filtered input of their pin
// - Aux source chosen before polarity and mask
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pmocp_top #(
  parameter int DEPTH = 4
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  input  wire pmocp_pkg::pmocp_cmp_s cmp_i,
  input  wire pmocp_pkg::pmocp_src_s src_i,
  input  wire logic [15:0]          cnt_value_i,
  input  wire logic [7:0]           fault_in,
  input  wire logic [2:0]           cap_pin,
  output logic [2:0]                pwm_o,
  output logic [2:0]                pwm_oe_n,
  output logic [5:0]                trig_o,
  output logic [24:0]               frac_cmp_o,
  output logic [9:0]                dt_frac_o,
  output logic                      dma_wr_req_o,
  output logic [5:0]                dma_rd_req_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [2:0]                   frac_en;
    logic                         post;
    logic                         flt_sts;
    logic [1:0][15:0]             dt;
    logic [4:0][4:0]              frac;
    logic [5:0]                   trig_en;
    logic [2:0]                   inv;
    logic [2:0]                   mask_buf;
    logic [2:0]                   mask_act;
    logic [2:0]                   out_en;
    logic [2:0]                   fstate;
    pmocp_pkg::pmocp_aux_e        aux_sel;
    logic [2:0][7:0]              fmap;
    logic                         cap_en;
    logic                         oneshot;
    pmocp_pkg::pmocp_capsrc_e     cap_src;
    pmocp_pkg::pmocp_edge_e       edge0;
    pmocp_pkg::pmocp_edge_e       edge1;
    logic [2:0]                   wm;
    logic [7:0]                   filt_per;
    logic [2:0]                   filt_cnt;
    logic [7:0]                   ecmp;
    logic                         wr_dma;
    logic                         cap_dma;
    pmocp_pkg::pmocp_dmasrc_e     dma_src;
    logic [5:0]                   fifo_dma;
    logic                         reload_flag;
    logic [7:0]                   fsync1;
    logic [7:0]                   fsync2;
    logic [2:0]                   csync1;
    logic [2:0]                   csync2;
    logic [2:0][7:0]              presc;
    logic [2:0][2:0]              agree;
    logic [2:0]                   filt;
    logic [2:0]                   filt_d;
    logic [2:0][7:0]              ecnt;
    logic [1:0][10:0]             dt_cnt;
    logic [1:0]                   dt_out;
    logic [5:0][DEPTH-1:0][15:0]  mem;
    logic [5:0][AW-1:0]           wp;
    logic [5:0][AW-1:0]           rp;
    logic [5:0][AW:0]             cnt;
    logic [2:0]                   pwm;
    logic [2:0]                   oe_n;
    logic [5:0]                   trig;
    logic [24:0]                  frac_o;
    logic [9:0]                   dt_frac;
    logic                         dma_wr;
    logic [5:0]                   dma_rd;
    logic                         ack;
    logic [31:0]                  dat;
  } pmocp_state_s;

  pmocp_state_s s_r;
  pmocp_state_s s_nxt;

  logic        req;
  logic        capv_hit;
  logic [2:0]  capv_idx;
  logic [31:0] rd_img;
  logic [31:0] wr_img;
  logic [5:0]  push;
  logic [5:0]  pop;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic [2:0]  ecnt_hit;
  logic [2:0]  src_sel;
  logic [2:0]  fault_hit;
  logic [1:0]  dt_en;
  logic [1:0][10:0] dt_whole;
  logic        cap_any;

  // Byte-lane merge of a write into the current register image
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Capture edge match for one circuit
  function automatic logic edge_hit(input pmocp_pkg::pmocp_edge_e e, input logic r,
                                    input logic f);
    return ((e == pmocp_pkg::EDGE_RISE) && r) || ((e == pmocp_pkg::EDGE_FALL) && f) ||
           ((e == pmocp_pkg::EDGE_BOTH) && (r || f));
  endfunction

  // FIFO word count above the programmed watermark
  function automatic logic over_wm(input logic [AW:0] c, input logic [2:0] w);
    return int'(c) > int'(w);
  endfunction

  // Bus decode, read image and write image
  always_comb begin
    req      = wb_cyc_i && wb_stb_i && !s_r.ack;
    capv_hit = (wb_adr_i >= pmocp_pkg::OFS_CAPV0) && (wb_adr_i <= pmocp_pkg::OFS_CAPV5) &&
               (wb_adr_i[1:0] == 2'h0);
    capv_idx = 3'(wb_adr_i[7:2] - pmocp_pkg::OFS_CAPV0[7:2]);
    rd_img   = pmocp_pkg::RST_WORD;
    unique case (wb_adr_i)
      pmocp_pkg::OFS_CTRL: begin
        rd_img[pmocp_pkg::CTRL_FRAC_EN +: 3] = s_r.frac_en;
        rd_img[pmocp_pkg::CTRL_POST]         = s_r.post;
        rd_img[pmocp_pkg::CTRL_FLT_STS]      = s_r.flt_sts;
      end
      pmocp_pkg::OFS_DT0:  rd_img[15:0] = s_r.dt[0];
      pmocp_pkg::OFS_DT1:  rd_img[15:0] = s_r.dt[1];
      pmocp_pkg::OFS_FRAC: rd_img[24:0] = s_r.frac;
      pmocp_pkg::OFS_TRIG: rd_img[5:0]  = s_r.trig_en;
      pmocp_pkg::OFS_OUT: begin
        rd_img[pmocp_pkg::OUT_INV +: 3]  = s_r.inv;
        rd_img[pmocp_pkg::OUT_MASK +: 3] = s_r.mask_buf;
        rd_img[pmocp_pkg::OUT_EN +: 3]   = s_r.out_en;
        rd_img[pmocp_pkg::OUT_FST +: 3]  = s_r.fstate;
        rd_img[pmocp_pkg::OUT_AUX +: 2]  = s_r.aux_sel;
      end
      pmocp_pkg::OFS_FMAP: rd_img[23:0] = s_r.fmap;
      pmocp_pkg::OFS_CAP: begin
        rd_img[pmocp_pkg::CAP_EN]        = s_r.cap_en;
        rd_img[pmocp_pkg::CAP_ONESHOT]   = s_r.oneshot;
        rd_img[pmocp_pkg::CAP_SRC]       = s_r.cap_src;
        rd_img[pmocp_pkg::CAP_EDGE0 +: 2] = s_r.edge0;
        rd_img[pmocp_pkg::CAP_EDGE1 +: 2] = s_r.edge1;
        rd_img[pmocp_pkg::CAP_WM +: 3]   = s_r.wm;
      end
      pmocp_pkg::OFS_FILT: begin
        rd_img[pmocp_pkg::FILT_PER +: 8]  = s_r.filt_per;
        rd_img[pmocp_pkg::FILT_CNT +: 3]  = s_r.filt_cnt;
        rd_img[pmocp_pkg::FILT_ECMP +: 8] = s_r.ecmp;
      end
      pmocp_pkg::OFS_DMA: begin
        rd_img[pmocp_pkg::DMA_WR]        = s_r.wr_dma;
        rd_img[pmocp_pkg::DMA_CAP]       = s_r.cap_dma;
        rd_img[pmocp_pkg::DMA_SRC]       = s_r.dma_src;
        rd_img[pmocp_pkg::DMA_FIFO +: 6] = s_r.fifo_dma;
      end
      pmocp_pkg::OFS_STAT: begin
        rd_img[pmocp_pkg::STAT_RF] = s_r.reload_flag;
        for (int f = 0; f < 6; f++) begin
          rd_img[pmocp_pkg::STAT_CF + f] = over_wm(s_r.cnt[f], s_r.wm);
        end
        rd_img[pmocp_pkg::STAT_MASK +: 3] = s_r.mask_act;
        rd_img[pmocp_pkg::STAT_CAPEN]     = s_r.cap_en;
      end
      default: begin
        if (capv_hit) begin
          rd_img[15:0] = s_r.mem[capv_idx][s_r.rp[capv_idx]];
          rd_img[pmocp_pkg::CAPV_CNT +: AW+1] = s_r.cnt[capv_idx];
        end
      end
    endcase
    wr_img = wmerge(rd_img, wb_dat_i, wb_sel_i);
  end

  // Datapath helpers from registered state
  always_comb begin
    rise      = s_r.filt & ~s_r.filt_d;
    fall      = ~s_r.filt & s_r.filt_d;
    dt_en     = {s_r.frac_en[2], s_r.frac_en[1]};
    cap_any   = 1'b0;
    push      = '0;
    pop       = '0;
    ecnt_hit  = '0;
    for (int k = 0; k < 2; k++) begin
      // Fraction bits only shorten the whole count when fractions are on
      dt_whole[k] = dt_en[k] ? s_r.dt[k][15:5] : s_r.dt[k][10:0];
    end
    for (int p = 0; p < 3; p++) begin
      ecnt_hit[p] = (rise[p] || fall[p]) && (s_r.ecnt[p] + 8'h01 == s_r.ecmp) &&
                    (s_r.ecmp != 8'h00);
      for (int c = 0; c < 2; c++) begin
        if (s_r.cap_en && ((c == 0) ? s_r.edge0 : s_r.edge1) !=
            pmocp_pkg::NO_CAPTURE_EDGE) begin
          if (s_r.cap_src == pmocp_pkg::EDGE_COUNTER_CAPTURE_SOURCE) begin
            push[2*p+c] = ecnt_hit[p];
          end else begin
            push[2*p+c] = edge_hit((c == 0) ? s_r.edge0 : s_r.edge1, rise[p], fall[p]);
          end
        end
      end
    end
    cap_any = |push;
    for (int f = 0; f < 6; f++) begin
      // A full FIFO drops the new capture rather than overwrite old data
      push[f] = push[f] && (int'(s_r.cnt[f]) < DEPTH);
      pop[f]  = req && !wb_we_i && capv_hit && (int'(capv_idx) == f) &&
                (s_r.cnt[f] != '0);
    end
    unique case (s_r.aux_sel)
      pmocp_pkg::AUX_PIN:   src_sel[0] = src_i.pwmx_src;
      pmocp_pkg::AUX_PAIR0: src_sel[0] = s_r.dt_out[0];
      pmocp_pkg::AUX_PAIR1: src_sel[0] = s_r.dt_out[1];
      pmocp_pkg::AUX_LOW:   src_sel[0] = 1'b0;
    endcase
    src_sel[1] = s_r.dt_out[0];
    src_sel[2] = s_r.dt_out[1];
    for (int o = 0; o < 3; o++) begin
      fault_hit[o] = |(s_r.fsync2 & s_r.fmap[o]);
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = req;
    // Synchronisers: first stage feeds only the second
    s_nxt.fsync1 = fault_in;
    s_nxt.fsync2 = s_r.fsync1;
    s_nxt.csync1 = cap_pin;
    s_nxt.csync2 = s_r.csync1;
    if (req && !wb_we_i) begin
      s_nxt.dat = rd_img;
    end

    // Hardware-set reload flag; set wins over a same-cycle clear
    if (req && wb_we_i && (wb_adr_i == pmocp_pkg::OFS_STAT) && wr_img[pmocp_pkg::STAT_RF]) begin
      s_nxt.reload_flag = 1'b0;
    end
    if (cmp_i.reload_opp) begin
      s_nxt.reload_flag = 1'b1;
    end

    // Register writes
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        pmocp_pkg::OFS_CTRL: begin
          s_nxt.frac_en = wr_img[pmocp_pkg::CTRL_FRAC_EN +: 3];
          s_nxt.post    = wr_img[pmocp_pkg::CTRL_POST];
          s_nxt.flt_sts = wr_img[pmocp_pkg::CTRL_FLT_STS];
        end
        pmocp_pkg::OFS_DT0:  s_nxt.dt[0] = wr_img[15:0];
        pmocp_pkg::OFS_DT1:  s_nxt.dt[1] = wr_img[15:0];
        pmocp_pkg::OFS_FRAC: s_nxt.frac  = wr_img[24:0];
        pmocp_pkg::OFS_TRIG: s_nxt.trig_en = wr_img[5:0];
        pmocp_pkg::OFS_OUT: begin
          s_nxt.inv      = wr_img[pmocp_pkg::OUT_INV +: 3];
          s_nxt.mask_buf = wr_img[pmocp_pkg::OUT_MASK +: 3];
          s_nxt.out_en   = wr_img[pmocp_pkg::OUT_EN +: 3];
          s_nxt.fstate   = wr_img[pmocp_pkg::OUT_FST +: 3];
          s_nxt.aux_sel  = pmocp_pkg::pmocp_aux_e'(wr_img[pmocp_pkg::OUT_AUX +: 2]);
        end
        pmocp_pkg::OFS_FMAP: s_nxt.fmap = wr_img[23:0];
        pmocp_pkg::OFS_CAP: begin
          s_nxt.cap_en  = wr_img[pmocp_pkg::CAP_EN];
          s_nxt.oneshot = wr_img[pmocp_pkg::CAP_ONESHOT];
          s_nxt.cap_src = pmocp_pkg::pmocp_capsrc_e'(wr_img[pmocp_pkg::CAP_SRC]);
          s_nxt.edge0   = pmocp_pkg::pmocp_edge_e'(wr_img[pmocp_pkg::CAP_EDGE0 +: 2]);
          s_nxt.edge1   = pmocp_pkg::pmocp_edge_e'(wr_img[pmocp_pkg::CAP_EDGE1 +: 2]);
          s_nxt.wm      = wr_img[pmocp_pkg::CAP_WM +: 3];
        end
        pmocp_pkg::OFS_FILT: begin
          s_nxt.filt_per = wr_img[pmocp_pkg::FILT_PER +: 8];
          s_nxt.filt_cnt = wr_img[pmocp_pkg::FILT_CNT +: 3];
          s_nxt.ecmp     = wr_img[pmocp_pkg::FILT_ECMP +: 8];
        end
        pmocp_pkg::OFS_DMA: begin
          s_nxt.wr_dma   = wr_img[pmocp_pkg::DMA_WR];
          s_nxt.cap_dma  = wr_img[pmocp_pkg::DMA_CAP];
          s_nxt.dma_src  = pmocp_pkg::pmocp_dmasrc_e'(wr_img[pmocp_pkg::DMA_SRC]);
          s_nxt.fifo_dma = wr_img[pmocp_pkg::DMA_FIFO +: 6];
        end
        default: ;
      endcase
    end

    // Buffered mask moves to the live mask on force or software update
    if (cmp_i.force_out || (req && wb_we_i && (wb_adr_i == pmocp_pkg::OFS_CTRL) &&
        wr_img[pmocp_pkg::CTRL_SWUPD])) begin
      s_nxt.mask_act = s_r.mask_buf;
    end

    // One-shot: the capture that lands clears the enable after any write
    if (s_r.oneshot && cap_any) begin
      s_nxt.cap_en = 1'b0;
    end

    // Input filter, edge counter and capture FIFOs per pin
    for (int p = 0; p < 3; p++) begin
      s_nxt.filt_d[p] = s_r.filt[p];
      if (s_r.filt_per == 8'h00) begin
        s_nxt.filt[p]  = s_r.csync2[p];
        s_nxt.presc[p] = 8'h00;
        s_nxt.agree[p] = 3'h0;
      end else if (s_r.presc[p] >= s_r.filt_per - 8'h01) begin
        s_nxt.presc[p] = 8'h00;
        if (s_r.csync2[p] != s_r.filt[p]) begin
          if (s_r.agree[p] >= s_r.filt_cnt) begin
            s_nxt.filt[p]  = s_r.csync2[p];
            s_nxt.agree[p] = 3'h0;
          end else begin
            s_nxt.agree[p] = s_r.agree[p] + 3'h1;
          end
        end else begin
          s_nxt.agree[p] = 3'h0;
        end
      end else begin
        s_nxt.presc[p] = s_r.presc[p] + 8'h01;
      end
      if (!s_r.cap_en || ecnt_hit[p]) begin
        s_nxt.ecnt[p] = 8'h00;
      end else if (rise[p] || fall[p]) begin
        s_nxt.ecnt[p] = s_r.ecnt[p] + 8'h01;
      end
    end
    for (int f = 0; f < 6; f++) begin
      if (push[f]) begin
        s_nxt.mem[f][s_r.wp[f]] = cnt_value_i;
        s_nxt.wp[f] = AW'((int'(s_r.wp[f]) + 1) % DEPTH);
      end
      if (pop[f]) begin
        s_nxt.rp[f] = AW'((int'(s_r.rp[f]) + 1) % DEPTH);
      end
      if (push[f] && !pop[f]) begin
        s_nxt.cnt[f] = s_r.cnt[f] + 1'b1;
      end else if (pop[f] && !push[f]) begin
        s_nxt.cnt[f] = s_r.cnt[f] - 1'b1;
      end
      // Source select only matters once capture DMA is on
      s_nxt.dma_rd[f] = s_r.cap_dma && s_r.fifo_dma[f] &&
                        ((s_r.dma_src == pmocp_pkg::DMA_SRC_NONEMPTY) ?
                         (s_r.cnt[f] != '0) : over_wm(s_r.cnt[f], s_r.wm));
    end
    s_nxt.dma_wr = s_r.wr_dma && s_r.reload_flag;

    // Dead time: rising edge held back by the whole-cycle count
    for (int k = 0; k < 2; k++) begin
      if (!((k == 0) ? src_i.pwm23_src : src_i.pwm45_src)) begin
        s_nxt.dt_cnt[k] = 11'h000;
      end else if (s_r.dt_cnt[k] < dt_whole[k]) begin
        s_nxt.dt_cnt[k] = s_r.dt_cnt[k] + 11'h001;
      end
      s_nxt.dt_out[k] = ((k == 0) ? src_i.pwm23_src : src_i.pwm45_src) &&
                        (s_r.dt_cnt[k] >= dt_whole[k]);
      s_nxt.dt_frac[5*k +: 5] = dt_en[k] ? s_r.dt[k][4:0] : 5'h00;
    end

    // Fraction codes for compare one..five go to the delay line
    for (int i = 0; i < 5; i++) begin
      s_nxt.frac_o[5*i +: 5] = s_r.frac_en[(i + 1) / 2] ? s_r.frac[i] : 5'h00;
    end

    // Trigger gating; postscaler keeps only the last period
    s_nxt.trig = cmp_i.cmp_match & s_r.trig_en &
                 {6{!s_r.post || cmp_i.last_period}};

    // Output stage: polarity, mask, fault, enable
    for (int o = 0; o < 3; o++) begin
      s_nxt.pwm[o] = src_sel[o] ^ s_r.inv[o];
      if (s_r.mask_act[o]) begin
        s_nxt.pwm[o] = 1'b0;
      end
      if (fault_hit[o]) begin
        s_nxt.pwm[o] = s_r.flt_sts ? s_r.fstate[o] : 1'b0;
      end
      s_nxt.oe_n[o] = !s_r.out_en[o];
    end
  end

  // Single state register, synchronous reset to all zero except oe_n, which resets to all ones
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r      <= '0;
      s_r.oe_n <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o     = s_r.ack;
  assign wb_dat_o     = s_r.dat;
  assign pwm_o        = s_r.pwm;
  assign pwm_oe_n     = s_r.oe_n;
  assign trig_o       = s_r.trig;
  assign frac_cmp_o   = s_r.frac_o;
  assign dt_frac_o    = s_r.dt_frac;
  assign dma_wr_req_o = s_r.dma_wr;
  assign dma_rd_req_o = s_r.dma_rd;

endmodule // pmocp_top

`default_nettype wire

/* rtl/pmocp_pkg.sv */
// Constants and types shared by the PWM submodule output and capture path
package pmocp_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DT0   = 8'h04;
  localparam logic [7:0] OFS_DT1   = 8'h08;
  localparam logic [7:0] OFS_FRAC  = 8'h0c;
  localparam logic [7:0] OFS_TRIG  = 8'h10;
  localparam logic [7:0] OFS_OUT   = 8'h14;
  localparam logic [7:0] OFS_FMAP  = 8'h18;
  localparam logic [7:0] OFS_CAP   = 8'h1c;
  localparam logic [7:0] OFS_FILT  = 8'h20;
  localparam logic [7:0] OFS_DMA   = 8'h24;
  localparam logic [7:0] OFS_STAT  = 8'h28;
  localparam logic [7:0] OFS_CAPV0 = 8'h2c;
  localparam logic [7:0] OFS_CAPV5 = 8'h40;

  // Control register fields
  localparam int CTRL_FRAC_EN = 0;
  localparam int CTRL_POST    = 3;
  localparam int CTRL_SWUPD   = 4;
  localparam int CTRL_FLT_STS = 5;
  // Output register fields
  localparam int OUT_INV   = 0;
  localparam int OUT_MASK  = 4;
  localparam int OUT_EN    = 8;
  localparam int OUT_FST   = 12;
  localparam int OUT_AUX   = 16;
  // Capture control fields
  localparam int CAP_EN      = 0;
  localparam int CAP_ONESHOT = 1;
  localparam int CAP_SRC     = 2;
  localparam int CAP_EDGE0   = 4;
  localparam int CAP_EDGE1   = 6;
  localparam int CAP_WM      = 8;
  // Filter register fields
  localparam int FILT_PER  = 0;
  localparam int FILT_CNT  = 8;
  localparam int FILT_ECMP = 16;
  // DMA register fields
  localparam int DMA_WR   = 0;
  localparam int DMA_CAP  = 1;
  localparam int DMA_SRC  = 2;
  localparam int DMA_FIFO = 4;
  // Status register fields
  localparam int STAT_RF   = 0;
  localparam int STAT_CF   = 1;
  localparam int STAT_MASK = 8;
  localparam int STAT_CAPEN = 12;
  // Capture value word fields
  localparam int CAPV_CNT = 16;

  // Dead time and fractional delay layout
  localparam int              FRAC_W        = 5;
  localparam logic [15:0]     DT_MAX_NOFRAC = 16'h07ff;
  localparam logic [15:0]     DT_MAX_FRAC   = 16'hffff;
  localparam logic [31:0]     RST_WORD      = 32'h0000_0000;

  typedef enum logic [1:0] {
    NO_CAPTURE_EDGE = 2'h0,
    EDGE_RISE       = 2'h1,
    EDGE_FALL       = 2'h2,
    EDGE_BOTH       = 2'h3
  } pmocp_edge_e;

  typedef enum logic {
    RAW_INPUT_SOURCE             = 1'b0,
    EDGE_COUNTER_CAPTURE_SOURCE  = 1'b1
  } pmocp_capsrc_e;

  typedef enum logic [1:0] {
    AUX_PIN   = 2'h0,
    AUX_PAIR0 = 2'h1,
    AUX_PAIR1 = 2'h2,
    AUX_LOW   = 2'h3
  } pmocp_aux_e;

  typedef enum logic {
    DMA_SRC_WATERMARK = 1'b0,
    DMA_SRC_NONEMPTY  = 1'b1
  } pmocp_dmasrc_e;

  // Events from the counter and force logic of the submodule
  typedef struct packed {
    logic [5:0] cmp_match;
    logic       reload_opp;
    logic       last_period;
    logic       force_out;
  } pmocp_cmp_s;

  // Raw signals from the force logic, ahead of dead time
  typedef struct packed {
    logic pwmx_src;
    logic pwm23_src;
    logic pwm45_src;
  } pmocp_src_s;

endpackage

/* bench/pmocp_monitor.sv */
// Port-level checks for the output and capture path, bound to its top
`timescale 1ns/100ps
`default_nettype none
module pmocp_monitor #(
  parameter int DEPTH = 4
) (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic                  wb_we_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic [31:0]           wb_dat_o,
  input wire pmocp_pkg::pmocp_cmp_s cmp_i,
  input wire logic [2:0]            pwm_oe_n,
  input wire logic [5:0]            trig_o,
  input wire logic                  dma_wr_req_o,
  input wire logic [5:0]            dma_rd_req_o
);
  logic       wr_tk, post_r, dwr_r, cdma_r;
  logic [2:0] en_r;
  // Shadow of the few control bits the checks lean on
  assign wr_tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {post_r, dwr_r, cdma_r, en_r} <= 6'h00;
    end else if (wr_tk) begin
      if (wb_adr_i == pmocp_pkg::OFS_CTRL) post_r <= wb_dat_i[3];
      if (wb_adr_i == pmocp_pkg::OFS_OUT) en_r <= wb_dat_i[10:8];
      if (wb_adr_i == pmocp_pkg::OFS_DMA) {cdma_r, dwr_r} <= wb_dat_i[1:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Bus handshake in two steps
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ONE: assert property (s_taken |=> s_answer)
    else $error("ack not one cycle");
  AST_UNMAPPED_ZERO: assert property (s_taken ##0 (!wb_we_i && wb_adr_i == 8'h44)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_TRIG_CAUSE: assert property (|trig_o |-> (trig_o & ~$past(cmp_i.cmp_match)) == 6'h00)
    else $error("trigger without match");
  AST_POST_GATE: assert property (|trig_o && post_r && $past(post_r) |-> $past(cmp_i.last_period))
    else $error("trigger outside last period");
  AST_OE_FOLLOWS: assert property ($stable(en_r) [*3] |-> pwm_oe_n == ~en_r)
    else $error("enable not on pins");
  AST_DWR_RAISE: assert property (dwr_r && cmp_i.reload_opp |-> ##[1:2] dma_wr_req_o)
    else $error("no write request");
  AST_DWR_GATE: assert property (dma_wr_req_o |-> dwr_r || $past(dwr_r))
    else $error("write request while off");
  AST_DRD_GATE: assert property (|dma_rd_req_o |-> cdma_r || $past(cdma_r))
    else $error("read request while off");
endmodule // pmocp_monitor
bind pmocp_top pmocp_monitor #(.DEPTH(DEPTH)) u_mon (.mclk(mclk), .rst_n(rst_n),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cmp_i(cmp_i),
  .pwm_oe_n(pwm_oe_n), .trig_o(trig_o), .dma_wr_req_o(dma_wr_req_o),
  .dma_rd_req_o(dma_rd_req_o));
`default_nettype wire

/* bench/pmocp_partner.sv */
// Far-side model: fault sense lines and capture pins
`timescale 1ns/100ps
`default_nettype none
module pmocp_partner (
  input  wire logic       mclk,
  input  wire logic [7:0] flt_req,
  input  wire logic [2:0] pin_req,
  output logic      [7:0] fault_in,
  output logic      [2:0] cap_pin
);
  // Every fault line is a wire of its own, both capture channels of a pin share its input
  always_ff @(posedge mclk) begin
    fault_in <= flt_req;
    cap_pin  <= pin_req;
  end
endmodule // pmocp_partner
`default_nettype wire

/* bench/test_pmocp_top.sv */
// Self-checking bench for the output and capture path
`timescale 1ns/100ps
`default_nettype none
module test_pmocp_top;
  logic                  mclk, rst_n, we, cyc, stb, ack, dwr;
  logic [7:0]            adr, flt, fin;
  logic [31:0]           dat, rdat, rq;
  logic [2:0]            pin, cpin, pwm, oe_n;
  logic [5:0]            trig, drd;
  logic [24:0]           fr;
  logic [9:0]            dtf;
  pmocp_pkg::pmocp_cmp_s cmp;
  pmocp_pkg::pmocp_src_s src;
  int                    fail_count, compares, cyc_n, n;

  pmocp_partner u_far (.mclk(mclk), .flt_req(flt), .pin_req(pin), .fault_in(fin),
    .cap_pin(cpin));
  pmocp_top #(.DEPTH(4)) dut (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .wb_dat_o(rdat), .cmp_i(cmp), .src_i(src), .cnt_value_i(16'h1234), .fault_in(fin),
    .cap_pin(cpin), .pwm_o(pwm), .pwm_oe_n(oe_n), .trig_o(trig), .frac_cmp_o(fr),
    .dt_frac_o(dtf), .dma_wr_req_o(dwr), .dma_rd_req_o(drd));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One classic bus cycle, request held until ack is seen
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    adr <= a;
    dat <= d;
    we  <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task st;
    repeat (3) @(negedge mclk);
  endtask
  // Compare events for one cycle, trigger seen one cycle on
  task pulse(input logic [5:0] m, input logic lp, input logic [5:0] e);
    @(posedge mclk);
    cmp.cmp_match <= m;
    cmp.last_period <= lp;
    @(posedge mclk);
    cmp.cmp_match <= 6'h00;
    @(negedge mclk);
    chk(trig, e);
  endtask
  // Hang guard, far beyond the roughly 150 cycles needed
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {rst_n, we, cyc, stb} = 4'h0;
    {adr, dat, flt, pin} = 51'h0;
    cmp = '0;
    src = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(oe_n, 3'b111);
    bus(1'b0, 8'h44, 32'h0);
    chk(rq, 32'h0);
    bus(1'b1, 8'h10, 32'h3f);
    for (int i = 0; i < 6; i++) pulse(6'h01 << i, 1'b0, 6'h01 << i);
    bus(1'b1, 8'h00, 32'h08);
    pulse(6'h3f, 1'b0, 6'h00);
    pulse(6'h3f, 1'b1, 6'h3f);
    // Aux held low ahead of inversion, then a buffered mask
    bus(1'b1, 8'h14, 32'h30707);
    st();
    chk({oe_n, pwm}, 6'h07);
    bus(1'b1, 8'h14, 32'h30777);
    st();
    chk(pwm, 3'b111);
    bus(1'b1, 8'h00, 32'h10);
    st();
    chk(pwm, 3'b000);
    bus(1'b1, 8'h14, 32'h30707);
    @(posedge mclk);
    cmp.force_out <= 1'b1;
    @(posedge mclk);
    cmp.force_out <= 1'b0;
    st();
    chk(pwm, 3'b111);
    bus(1'b1, 8'h14, 32'h30007);
    st();
    chk(oe_n, 3'b111);
    // Dead time of three whole cycles on the first pair
    bus(1'b1, 8'h14, 32'h700);
    bus(1'b1, 8'h04, 32'h3);
    src.pwm23_src <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pwm[1] !== 1'b1 && n < 20);
    chk(n, 6);
    bus(1'b1, 8'h00, 32'h06);
    bus(1'b1, 8'h08, 32'hffff);
    bus(1'b1, 8'h0c, 32'h108421);
    bus(1'b0, 8'h08, 32'h0);
    chk(rq, 32'hffff);
    chk(dtf, 10'h3e3);
    chk(fr, 25'h108420);
    // Only the mapped fault line forces the fault value
    bus(1'b1, 8'h00, 32'h20);
    bus(1'b1, 8'h14, 32'h31700);
    bus(1'b1, 8'h18, 32'h10);
    flt <= 8'h01;
    st();
    st();
    chk(pwm[0], 1'b0);
    flt <= 8'h10;
    st();
    st();
    chk(pwm[0], 1'b1);
    // One-shot capture, flag, read request, then pop
    bus(1'b1, 8'h24, 32'h13);
    bus(1'b1, 8'h1c, 32'h13);
    pin <= 3'b001;
    n = 0;
    do begin
      bus(1'b0, 8'h28, 32'h0);
      n++;
    end while (rq[1] !== 1'b1 && n < 12);
    chk(rq[1], 1'b1);
    chk(rq[12], 1'b0);
    chk(drd, 6'h01);
    bus(1'b0, 8'h2c, 32'h0);
    chk(rq[16:0], 17'h11234);
    bus(1'b0, 8'h28, 32'h0);
    chk(rq[1], 1'b0);
    @(posedge mclk);
    cmp.reload_opp <= 1'b1;
    @(posedge mclk);
    cmp.reload_opp <= 1'b0;
    st();
    chk(dwr, 1'b1);
    bus(1'b1, 8'h28, 32'h1);
    st();
    chk(dwr, 1'b0);
    // Edge counter source: both edges hit at compare one, fall select ignored
    bus(1'b1, 8'h20, 32'h10000);
    bus(1'b1, 8'h1c, 32'h25);
    pin <= 3'b000;
    repeat (6) @(posedge mclk);
    pin <= 3'b001;
    repeat (6) @(posedge mclk);
    bus(1'b0, 8'h2c, 32'h0);
    chk(rq[18:16], 3'h2);
    complete_run();
  end
endmodule // test_pmocp_top
`default_nettype wire
